// ---- verilog/tpm_regs.svh ----
// What this block does
// - Pins drive low until control field written
// - Top bit 0: compare; bit 2 initial level, except low bits 00
// - Compare low bits 10: pin 1 on match
// - Compare low bits 11: toggle on match
// - Top bit 1, low 00: capture rising edge
// - Capture low bits 01: capture falling edge
// - Capture bit 1 set: capture both edges
// - Buffer mode: no events, setting ignored
// - Five 8-bit read/write irq enable registers
// - Bit 7 gates converter start request
// - Bit 6 reserved, always reads one
// - Bit 5 underflow enable, channels 1, 2 only
// - Bit 4 gates overflow interrupt request
// - Bit 3 fourth flag enable, channels 0,3,4
// - Bit 2 third flag enable, channels 0,3,4
// - Bit 1 gates second register interrupt
// - Bit 0 gates first register interrupt
// - Flags cleared by zero after reading one
// - Fourth flag set on match or capture
`ifndef TPM_REGS_SVH
`define TPM_REGS_SVH

// ==========================================================
// Register byte addresses
`define TPM_ADDR_PIN_CTRL 8'h00
`define TPM_ADDR_IER0 8'h04
`define TPM_IER_STRIDE 8'h04
`define TPM_ADDR_GR_THREE 8'h18
`define TPM_ADDR_GR_FOUR 8'h1C
`define TPM_ADDR_STATUS 8'h20

// ==========================================================
// Field layout and reset values
`define TPM_FIELD_W 4
`define TPM_FIELD_MODE_BIT 3
`define TPM_FIELD_INIT_BIT 2
`define TPM_IER_CONV_BIT 7
`define TPM_IER_UNDER_BIT 5
`define TPM_IER_OVER_BIT 4
`define TPM_IER_FOUR_BIT 3
`define TPM_IER_THREE_BIT 2
`define TPM_IER_TWO_BIT 1
`define TPM_IER_ONE_BIT 0
`define TPM_IER_RESET 8'h40
`define TPM_IER_MASK_COMMON 8'hD3
`define TPM_IER_MASK_UNDER 8'h20
`define TPM_IER_MASK_GRCD 8'h0C
`define TPM_STATUS_THREE_BIT 2
`define TPM_STATUS_FOUR_BIT 3
`define TPM_PIN_CTRL_RESET 8'h00
`define TPM_GR_RESET 16'hFFFF
`define TPM_RESP_OKAY 2'h0
`define TPM_RESP_SLVERR 2'h2

`endif

// ---- verilog/tpm_pkg.sv ----
package tpm_pkg;

  // ==========================================================
  // Pin modes, one-hot
  typedef enum logic [6:0] {
    TPM_OC_HOLD = 7'h01,
    TPM_OC_CLR = 7'h02,
    TPM_OC_SET = 7'h04,
    TPM_OC_TOG = 7'h08,
    TPM_IC_RISE = 7'h10,
    TPM_IC_FALL = 7'h20,
    TPM_IC_BOTH = 7'h40
  } tpm_mode_e;

  typedef logic [3:0] tpm_field_t;
  typedef logic [15:0] tpm_count_t;

  // Decode a 4-bit pin control field
  function automatic tpm_mode_e tpm_decode_mode(input tpm_field_t f);
    tpm_mode_e m;
    m = TPM_OC_HOLD;
    if (!f[3]) begin
      case (f[1:0])
        2'h1: m = TPM_OC_CLR;
        2'h2: m = TPM_OC_SET;
        2'h3: m = TPM_OC_TOG;
        default: m = TPM_OC_HOLD;
      endcase
    end else if (f[1]) begin
      m = TPM_IC_BOTH;
    end else if (f[0]) begin
      m = TPM_IC_FALL;
    end else begin
      m = TPM_IC_RISE;
    end
    return m;
  endfunction : tpm_decode_mode

endpackage : tpm_pkg

// ---- verilog/tpm_top.sv ----
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "tpm_regs.svh"

module tpm_top (
  input wire logic clock_i, // 50 MHz clock
  input wire logic rst_i, // Sync reset, high
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i, // Byte strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Response valid
  input wire logic s_axi_bready_i, // Response ready
  input wire logic [7:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [31:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read valid
  input wire logic s_axi_rready_i, // Read ready
  // Counter and channel 4 mode bits
  input wire tpm_pkg::tpm_count_t timer_counter_value_i, // Ch4 counter
  input wire logic buffer_mode_first_i, // Third reg is buffer
  input wire logic buffer_mode_second_i, // Fourth reg is buffer
  // Capture/compare pins, three and four
  input wire logic ch4_pin_three_i, // Pin level in
  output logic ch4_pin_three_o, // Pin level out
  output logic ch4_pin_three_oe_o, // Pin drive enable
  input wire logic ch4_pin_four_i, // Pin level in
  output logic ch4_pin_four_o, // Pin level out
  output logic ch4_pin_four_oe_o, // Pin drive enable
  // Status flags from outside, per channel
  input wire logic [4:0] underflow_flag_i, // Underflow flags
  input wire logic [4:0] overflow_flag_i, // Overflow flags
  input wire logic [4:0] reg_one_match_flag_i, // First reg flags
  input wire logic [4:0] reg_two_match_flag_i, // Second reg flags
  input wire logic [3:0] reg_three_match_flag_i, // Third, ch0-3
  input wire logic [3:0] reg_four_match_flag_i, // Fourth, ch0-3
  input wire logic [4:0] reg_one_event_i, // First reg match pulse
  // Requests
  output logic [4:0] underflow_irq_o, // Underflow requests
  output logic [4:0] overflow_irq_o, // Overflow requests
  output logic [4:0] reg_one_irq_o, // First reg requests
  output logic [4:0] reg_two_irq_o, // Second reg requests
  output logic [4:0] reg_three_irq_o, // Third reg requests
  output logic [4:0] reg_four_irq_o, // Fourth reg requests
  output logic [4:0] converter_start_o // Converter start pulses
);
  import tpm_pkg::*;

  // ==========================================================
  // Helpers
  // Writable bits of one channel's enable register
  function automatic logic [7:0] ier_mask(input int unsigned ch);
    logic [7:0] m;
    m = `TPM_IER_MASK_COMMON;
    if (ch == 1 || ch == 2) begin
      m = m | `TPM_IER_MASK_UNDER;
    end else begin
      m = m | `TPM_IER_MASK_GRCD;
    end
    return m;
  endfunction : ier_mask

  // Byte address of one channel's enable register
  function automatic logic [7:0] ier_addr(input int unsigned ch);
    return `TPM_ADDR_IER0 + (`TPM_IER_STRIDE * 8'(ch));
  endfunction : ier_addr

  // ==========================================================
  // Bus handshake
  logic aw_have_reg, aw_have_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_value;

  // Register state
  logic [7:0] pin_ctrl_reg, pin_ctrl_next;
  logic [7:0] ier_reg [5], ier_next [5];
  logic written_reg, written_next;
  tpm_count_t gr_reg [2], gr_next [2];
  logic [1:0] flag_reg, flag_next;
  logic [1:0] armed_reg, armed_next;

  // Pin state
  logic [1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [1:0] filt_reg, filt_next;
  logic [1:0] eq_prev_reg, eq_prev_next;
  logic [1:0] lvl_reg, lvl_next;
  logic [1:0] oe_reg, oe_next;
  logic [1:0] pin_in;
  logic [1:0] buf_mode;
  logic [1:0] eq_now;
  logic [1:0] evt;
  logic pin_ctrl_wr;
  tpm_mode_e mode [2];

  assign s_axi_awready_o = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_have_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid_i && !rvalid_reg;
  assign wr_addr = {aw_addr_reg[7:2], 2'h0};
  assign rd_addr = {s_axi_araddr_i[7:2], 2'h0};
  assign pin_ctrl_wr = wr_fire && wr_addr == `TPM_ADDR_PIN_CTRL && w_strb_reg[0];

  // Address decode for both directions
  always_comb begin
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rd_value = 32'h0000_0000;
    if (wr_addr == `TPM_ADDR_PIN_CTRL || wr_addr == `TPM_ADDR_GR_THREE ||
        wr_addr == `TPM_ADDR_GR_FOUR || wr_addr == `TPM_ADDR_STATUS) begin
      wr_hit = 1'b1;
    end
    case (rd_addr)
      `TPM_ADDR_PIN_CTRL: begin
        rd_hit = 1'b1;
        rd_value = {24'h00_0000, pin_ctrl_reg};
      end
      `TPM_ADDR_GR_THREE: begin
        rd_hit = 1'b1;
        rd_value = {16'h0000, gr_reg[0]};
      end
      `TPM_ADDR_GR_FOUR: begin
        rd_hit = 1'b1;
        rd_value = {16'h0000, gr_reg[1]};
      end
      `TPM_ADDR_STATUS: begin
        rd_hit = 1'b1;
        rd_value = 32'h0000_0000;
        rd_value[`TPM_STATUS_THREE_BIT] = flag_reg[0];
        rd_value[`TPM_STATUS_FOUR_BIT] = flag_reg[1];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    for (int ch = 0; ch < 5; ch++) begin
      if (wr_addr == ier_addr(ch)) begin
        wr_hit = 1'b1;
      end
      if (rd_addr == ier_addr(ch)) begin
        rd_hit = 1'b1;
        rd_value = {24'h00_0000, ier_reg[ch]};
      end
    end
  end

  // Next values of the handshake
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata_i;
      w_strb_next = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `TPM_RESP_OKAY : `TPM_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next = rd_value;
      rresp_next = rd_hit ? `TPM_RESP_OKAY : `TPM_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  // Handshake registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TPM_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `TPM_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Capture and compare events
  assign pin_in = {ch4_pin_four_i, ch4_pin_three_i};
  assign buf_mode = {buffer_mode_second_i, buffer_mode_first_i};

  // Mode decode, match and edge detection per pin
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic stable;
      logic rise;
      logic fall;
      stable = sync2_reg[i] == sync3_reg[i];
      rise = stable && sync3_reg[i] && !filt_reg[i];
      fall = stable && !sync3_reg[i] && filt_reg[i];
      filt_next[i] = stable ? sync3_reg[i] : filt_reg[i];
      mode[i] = tpm_decode_mode(pin_ctrl_reg[i*`TPM_FIELD_W +: `TPM_FIELD_W]);
      eq_now[i] = timer_counter_value_i == gr_reg[i];
      eq_prev_next[i] = eq_now[i];
      evt[i] = 1'b0;
      if (!buf_mode[i]) begin
        case (mode[i])
          TPM_OC_HOLD, TPM_OC_CLR, TPM_OC_SET, TPM_OC_TOG: evt[i] = eq_now[i] && !eq_prev_reg[i];
          TPM_IC_RISE: evt[i] = rise;
          TPM_IC_FALL: evt[i] = fall;
          TPM_IC_BOTH: evt[i] = rise || fall;
          default: evt[i] = 1'b0;
        endcase
      end
    end
  end

  // Pin level and drive
  always_comb begin
    lvl_next = lvl_reg;
    oe_next = oe_reg;
    for (int i = 0; i < 2; i++) begin
      logic [3:0] nf;
      nf = w_data_reg[i*`TPM_FIELD_W +: `TPM_FIELD_W];
      if (pin_ctrl_wr && !buf_mode[i]) begin
        oe_next[i] = !nf[`TPM_FIELD_MODE_BIT];
        if (!nf[`TPM_FIELD_MODE_BIT] && nf[1:0] != 2'h0) begin
          lvl_next[i] = nf[`TPM_FIELD_INIT_BIT];
        end
      end else if (written_reg && evt[i]) begin
        case (mode[i])
          TPM_OC_CLR: lvl_next[i] = 1'b0;
          TPM_OC_SET: lvl_next[i] = 1'b1;
          TPM_OC_TOG: lvl_next[i] = !lvl_reg[i];
          default: lvl_next[i] = lvl_reg[i];
        endcase
      end
    end
  end

  // Pin registers; synchroniser has three stages
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      filt_reg <= 2'h0;
      eq_prev_reg <= 2'h0;
      lvl_reg <= 2'h0;
      oe_reg <= 2'h3;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      eq_prev_reg <= eq_prev_next;
      lvl_reg <= lvl_next;
      oe_reg <= oe_next;
    end
  end

  assign ch4_pin_three_o = lvl_reg[0];
  assign ch4_pin_four_o = lvl_reg[1];
  assign ch4_pin_three_oe_o = oe_reg[0];
  assign ch4_pin_four_oe_o = oe_reg[1];

  // ==========================================================
  // Software registers and channel 4 flags
  always_comb begin
    pin_ctrl_next = pin_ctrl_reg;
    written_next = written_reg || pin_ctrl_wr;
    gr_next = gr_reg;
    flag_next = flag_reg;
    armed_next = armed_reg;
    ier_next = ier_reg;
    if (pin_ctrl_wr) begin
      pin_ctrl_next = w_data_reg[7:0];
    end
    for (int ch = 0; ch < 5; ch++) begin
      if (wr_fire && wr_addr == ier_addr(ch) && w_strb_reg[0]) begin
        ier_next[ch] = (w_data_reg[7:0] & ier_mask(ch)) | `TPM_IER_RESET;
      end
    end
    if (wr_fire && wr_addr == `TPM_ADDR_GR_THREE) begin
      if (w_strb_reg[0]) gr_next[0][7:0] = w_data_reg[7:0];
      if (w_strb_reg[1]) gr_next[0][15:8] = w_data_reg[15:8];
    end
    if (wr_fire && wr_addr == `TPM_ADDR_GR_FOUR) begin
      if (w_strb_reg[0]) gr_next[1][7:0] = w_data_reg[7:0];
      if (w_strb_reg[1]) gr_next[1][15:8] = w_data_reg[15:8];
    end
    if (rd_fire && rd_addr == `TPM_ADDR_STATUS) begin
      armed_next = armed_reg | flag_reg;
    end
    if (wr_fire && wr_addr == `TPM_ADDR_STATUS && w_strb_reg[0]) begin
      if (armed_reg[0] && !w_data_reg[`TPM_STATUS_THREE_BIT]) flag_next[0] = 1'b0;
      if (armed_reg[1] && !w_data_reg[`TPM_STATUS_FOUR_BIT]) flag_next[1] = 1'b0;
      armed_next = 2'h0;
    end
    for (int i = 0; i < 2; i++) begin
      if (evt[i]) begin
        flag_next[i] = 1'b1;
        if (mode[i] == TPM_IC_RISE || mode[i] == TPM_IC_FALL || mode[i] == TPM_IC_BOTH) begin
          gr_next[i] = timer_counter_value_i;
        end
      end
    end
  end

  // Software register storage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_ctrl_reg <= `TPM_PIN_CTRL_RESET;
      written_reg <= 1'b0;
      gr_reg[0] <= `TPM_GR_RESET;
      gr_reg[1] <= `TPM_GR_RESET;
      flag_reg <= 2'h0;
      armed_reg <= 2'h0;
      for (int ch = 0; ch < 5; ch++) begin
        ier_reg[ch] <= `TPM_IER_RESET;
      end
    end else begin
      pin_ctrl_reg <= pin_ctrl_next;
      written_reg <= written_next;
      gr_reg <= gr_next;
      flag_reg <= flag_next;
      armed_reg <= armed_next;
      ier_reg <= ier_next;
    end
  end

  // ==========================================================
  // Interrupt requests and converter start
  logic [4:0] uirq_next, virq_next, airq_next, birq_next, cirq_next, dirq_next, conv_next;
  always_comb begin
    for (int ch = 0; ch < 5; ch++) begin
      logic fc;
      logic fd;
      fc = (ch == 4) ? flag_reg[0] : reg_three_match_flag_i[ch % 4];
      fd = (ch == 4) ? flag_reg[1] : reg_four_match_flag_i[ch % 4];
      uirq_next[ch] = underflow_flag_i[ch] && ier_reg[ch][`TPM_IER_UNDER_BIT];
      virq_next[ch] = overflow_flag_i[ch] && ier_reg[ch][`TPM_IER_OVER_BIT];
      airq_next[ch] = reg_one_match_flag_i[ch] && ier_reg[ch][`TPM_IER_ONE_BIT];
      birq_next[ch] = reg_two_match_flag_i[ch] && ier_reg[ch][`TPM_IER_TWO_BIT];
      cirq_next[ch] = fc && ier_reg[ch][`TPM_IER_THREE_BIT];
      dirq_next[ch] = fd && ier_reg[ch][`TPM_IER_FOUR_BIT];
      conv_next[ch] = reg_one_event_i[ch] && ier_reg[ch][`TPM_IER_CONV_BIT];
    end
  end

  // Request registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      underflow_irq_o <= 5'h00;
      overflow_irq_o <= 5'h00;
      reg_one_irq_o <= 5'h00;
      reg_two_irq_o <= 5'h00;
      reg_three_irq_o <= 5'h00;
      reg_four_irq_o <= 5'h00;
      converter_start_o <= 5'h00;
    end else begin
      underflow_irq_o <= uirq_next;
      overflow_irq_o <= virq_next;
      reg_one_irq_o <= airq_next;
      reg_two_irq_o <= birq_next;
      reg_three_irq_o <= cirq_next;
      reg_four_irq_o <= dirq_next;
      converter_start_o <= conv_next;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  pin_low_reset_a: assert property (!written_reg |-> (oe_reg == 2'h3 && lvl_reg == 2'h0))
    else $error("pin not driven low before setup");
  set_on_match_a: assert property ((written_reg && !pin_ctrl_wr && evt[0] && mode[0] == TPM_OC_SET)
    |=> ch4_pin_three_o)
    else $error("pin three not set on match");
  toggle_match_a: assert property ((written_reg && !pin_ctrl_wr && evt[0] && mode[0] == TPM_OC_TOG)
    |=> ch4_pin_three_o != $past(ch4_pin_three_o))
    else $error("pin three did not toggle");
  capture_load_a: assert property ((evt[1] && mode[1] == TPM_IC_BOTH)
    |=> gr_reg[1] == $past(timer_counter_value_i))
    else $error("capture did not load counter");
  buffer_quiet_a: assert property (buf_mode[0] |=> ch4_pin_three_o == $past(ch4_pin_three_o))
    else $error("pin changed while in buffer mode");
  reserved_one_a: assert property (ier_reg[2][6] && !ier_reg[2][3] && !ier_reg[0][5])
    else $error("fixed enable bits wrong");
  four_flag_set_a: assert property (evt[1] |=> flag_reg[1] [*1] ##1 (flag_reg[1] || $past(wr_fire)))
    else $error("fourth flag not set on event");
  irq_and_a: assert property ((flag_reg[1] && ier_reg[4][3]) [*2] |-> reg_four_irq_o[4])
    else $error("request missing with flag and enable");
  conv_gate_a: assert property (converter_start_o[0] |-> $past(reg_one_event_i[0]) && $past(ier_reg[0][7]))
    else $error("converter start without cause");

endmodule : tpm_top

// ---- verification/tpm_pin_model.sv ----
`timescale 1ns/100ps
// ==========
// Far-side pin source
module tpm_pin_model (
  input wire logic oe_i, // Block drives pin
  input wire logic out_i, // Block level
  input wire logic ext_i, // Outside level
  output logic pin_o // Wire level
);
  // Block wins while driving, else outside source
  assign pin_o = oe_i ? out_i : ext_i;
endmodule : tpm_pin_model

// ---- verification/test_timer_pin_mode_and_irq_enable.sv ----
`timescale 1ns/100ps
`include "tpm_regs.svh"
module test_timer_pin_mode_and_irq_enable;
  import tpm_pkg::*;
  logic clock_i = 0, rst_i = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awr, wrd, bv, arr, rv, bf1 = 0, bf2 = 0, ext3 = 0, ext4 = 0, p3, p4, o3, o4, oe3, oe4;
  logic [1:0] bresp, rresp, rs, bs;
  tpm_count_t cnt = 0, exp4 = 16'hFFFF;
  logic [4:0] fl = 0, ev = 0, uirq, virq, irq1, irq2, irq3, irq4, conv;
  int fails = 0, compares = 0;
  logic [3:0] of[4] = '{4'h2, 4'h5, 4'h7, 4'h3};
  logic oa[4] = '{1, 0, 0, 1};
  logic [3:0] cf[7] = '{4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hB, 4'hB};
  logic cc[7] = '{1, 0, 0, 1, 1, 1, 0};
  logic bb[7] = '{0, 0, 0, 0, 0, 0, 1};
  tpm_top DUT (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .timer_counter_value_i(cnt),
    .buffer_mode_first_i(bf1), .buffer_mode_second_i(bf2), .ch4_pin_three_i(p3), .ch4_pin_three_o(o3),
    .ch4_pin_three_oe_o(oe3), .ch4_pin_four_i(p4), .ch4_pin_four_o(o4), .ch4_pin_four_oe_o(oe4),
    .underflow_flag_i(fl), .overflow_flag_i(fl), .reg_one_match_flag_i(fl), .reg_two_match_flag_i(fl),
    .reg_three_match_flag_i(fl[3:0]), .reg_four_match_flag_i(fl[3:0]), .reg_one_event_i(ev),
    .underflow_irq_o(uirq), .overflow_irq_o(virq), .reg_one_irq_o(irq1), .reg_two_irq_o(irq2),
    .reg_three_irq_o(irq3), .reg_four_irq_o(irq4), .converter_start_o(conv));
  tpm_pin_model PIN3 (.oe_i(oe3), .out_i(o3), .ext_i(ext3), .pin_o(p3));
  tpm_pin_model PIN4 (.oe_i(oe4), .out_i(o4), .ext_i(ext4), .pin_o(p4));
  // ==========
  // Clock and watchdog
  initial forever #10 clock_i = ~clock_i;
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    results();
  end
  // ==========
  // Bench tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  // Write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clock_i);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    bs = bresp;
    bready <= 0;
  endtask : wr
  task rdr(input logic [7:0] a);
    @(posedge clock_i);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clock_i);
      if (arr) arv <= 0;
    end while (!rv);
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask : rdr
  // Counter meets the third register value for a few cycles
  task hit;
    @(posedge clock_i);
    cnt <= 16'h0100;
    repeat (3) @(posedge clock_i);
    cnt <= 16'h0000;
    tick(3);
  endtask : hit
  task pulse;
    @(posedge clock_i);
    ev <= 5'h1F;
    @(posedge clock_i);
    ev <= 5'h00;
    #1;
  endtask : pulse
  task results;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ==========
  // Test sequence
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 0;
    #1;
    chk({o3, oe3, o4, oe4}, 4'b0101);
    for (int c = 0; c < 5; c++) begin
      rdr(`TPM_ADDR_IER0 + 8'(c * 4));
      chk(rd, 32'h0000_0040);
      wr(`TPM_ADDR_IER0 + 8'(c * 4), 32'h0000_00FF);
      chk(bs, 2'h0);
      rdr(`TPM_ADDR_IER0 + 8'(c * 4));
      chk(rd, {24'h0, 8'hD3 | ((c == 1 || c == 2) ? 8'h20 : 8'h0C)});
    end
    fl <= 5'h1F;
    tick(3);
    chk({uirq, virq, irq1, irq2}, {5'h06, 5'h1F, 5'h1F, 5'h1F});
    chk({irq3[3:0], irq4[3:0]}, 8'h99);
    pulse();
    chk(conv, 5'h1F);
    for (int c = 0; c < 5; c++) wr(`TPM_ADDR_IER0 + 8'(c * 4), 32'h0000_0040);
    tick(2);
    chk({uirq, virq, irq1, irq2, irq3, irq4}, 30'h0);
    pulse();
    chk(conv, 5'h00);
    @(posedge clock_i) fl <= 5'h00;
    wr(`TPM_ADDR_GR_THREE, 32'h0000_0100);
    foreach (of[i]) begin
      wr(`TPM_ADDR_PIN_CTRL, {28'h0, of[i]});
      tick(2);
      chk({oe3, o3}, {1'b1, of[i][2]});
      hit();
      chk(o3, oa[i]);
    end
    hit();
    chk(o3, 1'b0);
    hit();
    wr(`TPM_ADDR_PIN_CTRL, 32'h0000_0000);
    hit();
    chk(o3, 1'b1);
    @(posedge clock_i) bf1 <= 1;
    wr(`TPM_ADDR_PIN_CTRL, 32'h0000_0005);
    hit();
    chk(o3, 1'b1);
    @(posedge clock_i) bf1 <= 0;
    foreach (cf[i]) begin
      bf2 <= bb[i];
      wr(`TPM_ADDR_PIN_CTRL, {24'h0, cf[i], 4'h0});
      @(posedge clock_i);
      cnt <= 16'(16'h1111 * (i + 1));
      ext4 <= ~ext4;
      tick(8);
      if (cc[i]) exp4 = cnt;
      rdr(`TPM_ADDR_GR_FOUR);
      chk(rd, {16'h0, exp4});
    end
    bf2 <= 0;
    tick(1);
    chk(oe4, 1'b0);
    // Channel 4 third and fourth enables on the internal flags
    wr(`TPM_ADDR_IER0 + 8'h10, 32'h0000_004C);
    tick(1);
    chk({irq3[4], irq4[4]}, 2'h3);
    rdr(`TPM_ADDR_STATUS);
    wr(`TPM_ADDR_STATUS, 32'h0000_00FF);
    rdr(`TPM_ADDR_STATUS);
    chk(rd[3:2], 2'h3);
    wr(`TPM_ADDR_STATUS, 32'h0000_0000);
    tick(1);
    chk({irq3[4], irq4[4]}, 2'h0);
    rdr(`TPM_ADDR_STATUS);
    chk(rd[3:2], 2'h0);
    rdr(8'h40);
    chk({rs, rd}, {2'h2, 32'h0});
    wr(8'h40, 32'h0000_0000);
    chk(bs, 2'h2);
    results();
  end
endmodule : test_timer_pin_mode_and_irq_enable
